// ===== rtl/pism_top.sv
// Function
// - event edge latches status bit until cleared
// - writing one clears bit, zero keeps it
// - fail bits re-set while pins held, clear ignored meanwhile
// - monitor and mailbox bits 23:16, 31:24 reserved
// - fail, software, error, DMA bits 15:8
// - VME levels bits 7:1, ownership bit 0
// - status and routes reset to zero
// - three-bit field picks one of eight outputs
// - first route register holds levels, ownership
// - second route register holds sources 15:8
// - enable bit gates each source
// - level acknowledge sets status, blocks refetch
//
// Design decision made here: the AXI4-Lite interface to the registers.
`include "pism_defs.svh"
`default_nettype none
module pism_top
  import pism_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [3:0] location_monitor_event, // monitor hits
  input wire logic [3:0] mailbox_event, // mailbox writes
  input wire logic ac_fail_level, // ac fail pin, high active
  input wire logic sys_fail_level, // sys fail pin, high active
  input wire logic software_acknowledge_event, // sw ack
  input wire logic vme_error_event, // vme bus error
  input wire logic pci_error_event, // pci bus error
  input wire logic dma_event, // dma done
  input wire logic [7:1] vme_level_interrupt, // ack done
  input wire logic bus_ownership_event, // bus granted
  output logic [7:1] vme_level_fetch_ok, // may fetch vector
  output logic [7:0] pci_interrupt_out_n, // pci pins
  output logic irq // any enabled status set
);

  logic aw_hold_q;
  logic w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  pism_resp_t bresp_q;
  logic rvalid_q;
  pism_resp_t rresp_q;
  logic [31:0] rdata_q;
  logic do_wr;
  logic [31:0] bmask;
  logic wr_known;
  pism_src_t en_q;
  pism_src_t status_q;
  pism_src_t status_d;
  pism_src_t src;
  pism_src_t src_q;
  pism_src_t set_v;
  pism_src_t clr_v;
  pism_src_t active;
  logic [31:0] route_a_q;
  logic [31:0] route_b_q;
  pism_dest_t dest [24];
  logic [7:0][23:0] match;
  logic [7:0] hit;
  logic [7:0] out_n_q;
  logic irq_q;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // register slave: address and data may arrive in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign do_wr = aw_hold_q && w_hold_q;

  assign bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
    {8{wstrb_q[0]}}};

  always_comb
  begin
    case (awaddr_q)
      `PISM_EN_OFS,
      `PISM_STAT_OFS,
      `PISM_ROUTE_A_OFS,
      `PISM_ROUTE_B_OFS: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (do_wr)
      aw_hold_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_wr)
      w_hold_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `PISM_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? `PISM_RESP_OKAY : `PISM_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `PISM_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `PISM_RESP_OKAY;
      case (s_axi_araddr)
        `PISM_EN_OFS: rdata_q <= {8'h00, en_q};
        `PISM_STAT_OFS: rdata_q <= {8'h00, status_q};
        `PISM_ROUTE_A_OFS: rdata_q <= route_a_q;
        `PISM_ROUTE_B_OFS: rdata_q <= route_b_q;
        default:
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= `PISM_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_q <= `PISM_EN_RST;
    else if (do_wr && awaddr_q == `PISM_EN_OFS)
      en_q <= ((en_q & ~bmask[23:0]) | (wdata_q[23:0] & bmask[23:0]))
        & `PISM_STAT_VALID;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      route_a_q <= `PISM_ROUTE_RST;
      route_b_q <= `PISM_ROUTE_RST;
    end
    else if (do_wr && awaddr_q == `PISM_ROUTE_A_OFS)
      route_a_q <= ((route_a_q & ~bmask) | (wdata_q & bmask))
        & `PISM_ROUTE_A_MASK;
    else if (do_wr && awaddr_q == `PISM_ROUTE_B_OFS)
      route_b_q <= ((route_b_q & ~bmask) | (wdata_q & bmask))
        & `PISM_ROUTE_B_MASK;
  end

  // source order matches the status layout bit for bit
  // software interrupt fires on a rising edge of its enable bit
  assign src = {location_monitor_event, mailbox_event,
    ac_fail_level, sys_fail_level, en_q[`PISM_BIT_SWINT],
    software_acknowledge_event, 1'b0, vme_error_event,
    pci_error_event, dma_event,
    vme_level_interrupt, bus_ownership_event};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_q <= `PISM_STAT_RST;
    else
      src_q <= src;
  end
  // fail pins are level sources: a held pin re-sets every cycle
  assign set_v = ((src & ~src_q) | (src & `PISM_LEVEL_MASK))
    & `PISM_STAT_VALID;
  assign clr_v = (do_wr && awaddr_q == `PISM_STAT_OFS) ?
    wdata_q[23:0] & bmask[23:0] : `PISM_STAT_RST;
  // set beats clear so an event in the clear cycle is kept
  assign status_d = ((status_q & ~clr_v) | set_v)
    & `PISM_STAT_VALID;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= `PISM_STAT_RST;
    else
      status_q <= status_d;
  end
  // no vector refetch at a level until its status is cleared
  assign vme_level_fetch_ok = en_q[7:1] & ~status_q[7:1];
  assign active = status_q & en_q;
  // monitor and mailbox sources have no route field
  genvar gi, go;
  generate
    for (gi = 0; gi < `PISM_SRC_W; gi++)
    begin : g_dest
      if (gi < 8)
      begin : g_a
        assign dest[gi] = route_a_q[4*gi +: 3];
      end
      else if (gi < 16)
      begin : g_b
        assign dest[gi] = route_b_q[4*(gi-8) +: 3];
      end
      else
      begin : g_f
        assign dest[gi] = `PISM_FIXED_DEST;
      end
      for (go = 0; go < 8; go++)
      begin : g_m
        assign match[go][gi] = (dest[gi] == 3'(go));
      end
    end
    for (go = 0; go < 8; go++)
    begin : g_out
      assign hit[go] = |(active & match[go]);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_n_q <= `PISM_OUT_IDLE;
      irq_q <= 1'b0;
    end
    else
    begin
      out_n_q <= ~hit;
      irq_q <= |active;
    end
  end
  assign pci_interrupt_out_n = out_n_q;
  assign irq = irq_q;

  sequence clr_req;
    (clr_v & ~set_v) != 24'h000000;
  endsequence
  sequence ev_req;
    set_v != 24'h000000;
  endsequence
  w1c_clear_a: assert property (clr_req |=>
    (status_q & $past(clr_v & ~set_v)) == 24'h000000)
    else $error("status bit not cleared by write of one");
  sticky_set_a: assert property (ev_req |=>
    (status_q & $past(set_v)) == $past(set_v))
    else $error("event did not latch status");
  fail_level_a: assert property ((ac_fail_level || sys_fail_level) |=>
    (status_q[15:14] & $past({ac_fail_level, sys_fail_level})) ==
      $past({ac_fail_level, sys_fail_level}))
    else $error("fail status dropped while pin held");
  reserved_bit_a: assert property (status_q[`PISM_BIT_RSVD] == 1'b0)
    else $error("reserved status bit set");
  level_block_a: assert property ((set_v[7:1] != 7'h00) |=>
    (vme_level_fetch_ok & $past(set_v[7:1])) == 7'h00)
    else $error("refetch allowed after acknowledge");
  reset_zero_a: assert property ($rose(rst_n) |-> status_q == 24'h000000
    && route_a_q == 32'h0 && route_b_q == 32'h0)
    else $error("state not zero after reset");
  default_route_a: assert property ((active != 24'h000000
    && route_a_q == 32'h0 && route_b_q == 32'h0) |=> !pci_interrupt_out_n[0])
    else $error("default route not on output zero");
  enable_gate_a: assert property ((en_q == 24'h000000) |=>
    (pci_interrupt_out_n == 8'hFF && !irq))
    else $error("disabled source drove an output");
  idle_out_a: assert property ((active == 24'h000000) ##1
    (active == 24'h000000) |-> pci_interrupt_out_n == 8'hFF)
    else $error("output asserted with nothing active");
  route_a_sel_a: assert property ((active == 24'h000080) |=>
    !pci_interrupt_out_n[$past(route_a_q[30:28])])
    else $error("level seven misrouted");
  route_b_sel_a: assert property ((active == 24'h000100) |=>
    !pci_interrupt_out_n[$past(route_b_q[2:0])])
    else $error("dma misrouted");

endmodule : pism_top
`default_nettype wire

// ===== shared/pism_defs.svh
`ifndef PISM_DEFS_SVH
`define PISM_DEFS_SVH
`define PISM_ADDR_W 12
`define PISM_EN_OFS 12'h300
`define PISM_STAT_OFS 12'h304
`define PISM_ROUTE_A_OFS 12'h308
`define PISM_ROUTE_B_OFS 12'h30C
`define PISM_SRC_W 24
`define PISM_STAT_VALID 24'hFFF7FF
`define PISM_LEVEL_MASK 24'h00C000
`define PISM_ROUTE_A_MASK 32'h77777777
`define PISM_ROUTE_B_MASK 32'h77770777
`define PISM_STAT_RST 24'h000000
`define PISM_EN_RST 24'h000000
`define PISM_ROUTE_RST 32'h00000000
`define PISM_OUT_IDLE 8'hFF
`define PISM_BIT_ACFAIL 15
`define PISM_BIT_SYSFAIL 14
`define PISM_BIT_SWINT 13
`define PISM_BIT_RSVD 11
`define PISM_FIXED_DEST 3'h0
`define PISM_RESP_OKAY 2'h0
`define PISM_RESP_SLVERR 2'h2
`endif

// ===== shared/pism_pkg.sv
`default_nettype none
package pism_pkg;
  typedef logic [2:0] pism_dest_t;
  typedef logic [1:0] pism_resp_t;
  typedef logic [23:0] pism_src_t;
endpackage : pism_pkg
`default_nettype wire

// ===== dv/pism_host.sv
`default_nettype none
module pism_host
(
  input wire logic clk, // bus clock
  output var logic [11:0] awaddr, // write address
  output var logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output var logic [31:0] wdata, // write data
  output var logic [3:0] wstrb, // byte strobes
  output var logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output var logic bready, // write response ready
  output var logic [11:0] araddr, // read address
  output var logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output var logic rready // read data ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // handshakes are sampled at the rising edge, before the slave updates
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r, input logic [3:0] s = 4'hF);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready)
      begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : pism_host
`default_nettype wire

// ===== dv/pism_top_tb.sv
`include "pism_defs.svh"
`default_nettype none
module pism_top_tb
  import pism_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] ev = '0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  pism_resp_t bresp, rresp, rs;
  logic [7:1] fok;
  logic [7:0] out_n;
  int bad_count = 0;
  int check_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  pism_host HOST (.clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  pism_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .location_monitor_event(ev[23:20]), .mailbox_event(ev[19:16]),
    .ac_fail_level(ev[15]), .sys_fail_level(ev[14]),
    .software_acknowledge_event(ev[12]), .vme_error_event(ev[10]),
    .pci_error_event(ev[9]), .dma_event(ev[8]),
    .vme_level_interrupt(ev[7:1]), .bus_ownership_event(ev[0]),
    .vme_level_fetch_ok(fok), .pci_interrupt_out_n(out_n), .irq(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // one-cycle pulse; status and pins have settled when this returns
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev[i] <= 1'b0;
    cyc(4);
  endtask : pulse
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    HOST.rd(a, rv, rs);
    chk(rv, e);
  endtask : rdchk
  task automatic t_reset;
    rdchk(`PISM_EN_OFS, 32'h0);
    rdchk(`PISM_STAT_OFS, 32'h0);
    rdchk(`PISM_ROUTE_A_OFS, 32'h0);
    rdchk(`PISM_ROUTE_B_OFS, 32'h0);
    chk({23'h0, out_n, irq}, {23'h0, 8'hFF, 1'b0});
    HOST.rd(12'h310, rv, rs);
    chk({30'h0, rs}, {30'h0, `PISM_RESP_SLVERR});
    chk(rv, 32'h0);
    HOST.wr(12'h310, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, {30'h0, `PISM_RESP_SLVERR});
    $display("test reset done");
  endtask : t_reset
  task automatic t_route;
    HOST.wr(`PISM_ROUTE_A_OFS, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, {30'h0, `PISM_RESP_OKAY});
    rdchk(`PISM_ROUTE_A_OFS, 32'h77777777);
    HOST.wr(`PISM_ROUTE_B_OFS, 32'hFFFFFFFF, rs);
    rdchk(`PISM_ROUTE_B_OFS, 32'h77770777);
    HOST.wr(`PISM_ROUTE_A_OFS, 32'h0, rs);
    // only byte lane one is written
    HOST.wr(`PISM_ROUTE_A_OFS, 32'hFFFFFFFF, rs, 4'h2);
    rdchk(`PISM_ROUTE_A_OFS, 32'h00007700);
    HOST.wr(`PISM_ROUTE_A_OFS, 32'h0, rs);
    HOST.wr(`PISM_ROUTE_B_OFS, 32'h0, rs);
    $display("test route done");
  endtask : t_route
  task automatic t_bits;
    // enabling bit 13 from zero raises the software interrupt
    HOST.wr(`PISM_EN_OFS, 32'hFFFFFFFF, rs);
    rdchk(`PISM_EN_OFS, 32'h00FFF7FF);
    rdchk(`PISM_STAT_OFS, 32'h00002000);
    HOST.wr(`PISM_STAT_OFS, 32'h00002000, rs);
    for (int i = 0; i < 24; i++)
    begin
      if (i == 11 || (i >= 13 && i <= 15))
        continue;
      pulse(i);
      rdchk(`PISM_STAT_OFS, 32'h1 << i);
      if (i >= 1 && i <= 7)
        chk(fok[i], 1'b0);
      HOST.wr(`PISM_STAT_OFS, 32'h0, rs);
      rdchk(`PISM_STAT_OFS, 32'h1 << i);
      HOST.wr(`PISM_STAT_OFS, 32'h1 << i, rs);
      rdchk(`PISM_STAT_OFS, 32'h0);
      if (i >= 1 && i <= 7)
        chk(fok[i], 1'b1);
    end
    $display("test bits done");
  endtask : t_bits
  task automatic t_fail;
    for (int i = 14; i < 16; i++)
    begin
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      cyc(3);
      HOST.wr(`PISM_STAT_OFS, 32'h1 << i, rs);
      rdchk(`PISM_STAT_OFS, 32'h1 << i);
      @(posedge sys_clk);
      ev[i] <= 1'b0;
      cyc(2);
      HOST.wr(`PISM_STAT_OFS, 32'h1 << i, rs);
      rdchk(`PISM_STAT_OFS, 32'h0);
    end
    $display("test fail done");
  endtask : t_fail
  task automatic t_map;
    for (int d = 0; d < 8; d++)
    begin
      HOST.wr(`PISM_ROUTE_B_OFS, d, rs);
      pulse(8);
      chk({out_n, irq}, {~(8'h01 << d), 1'b1});
      HOST.wr(`PISM_STAT_OFS, 32'h100, rs);
      cyc(3);
      chk({out_n, irq}, {8'hFF, 1'b0});
    end
    HOST.wr(`PISM_EN_OFS, 32'h0, rs);
    pulse(8);
    chk({out_n, irq}, {8'hFF, 1'b0});
    rdchk(`PISM_STAT_OFS, 32'h100);
    $display("test map done");
  endtask : t_map
  // reset in mid-run with status and a route field non-zero
  task automatic t_rerst;
    HOST.wr(`PISM_ROUTE_B_OFS, 32'h7, rs);
    pulse(0);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    cyc(2);
    chk({23'h0, out_n, irq}, {23'h0, 8'hFF, 1'b0});
    rst_n <= 1'b1;
    rdchk(`PISM_STAT_OFS, 32'h0);
    rdchk(`PISM_ROUTE_B_OFS, 32'h0);
    rdchk(`PISM_EN_OFS, 32'h0);
    $display("test rerst done");
  endtask : t_rerst
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  initial
  begin
    // about 750 cycles of traffic; forty times that is a hang
    #150us;
    bad_count++;
    finish_test();
  end
  initial
  begin
    cyc(8);
    rst_n <= 1'b1;
    t_reset();
    t_route();
    t_bits();
    t_fail();
    t_map();
    t_rerst();
    finish_test();
  end
endmodule : pism_top_tb
`default_nettype wire
